// >>> design/ipds_bank.v
// Function
// - a read-only 32-bit count of free pages in pool queue 0 is sampled every clock, reset zero.
// - a read-only 64-bit cycle counter is zero in reset and counts every clock after.
// - bits 60:54 of the page pointer fifo word read a fixed capacity of eight.
// - in no-work-entry-pointer mode that capacity counts packet pointers only.
// - bits 53:46 and 45:38 show the work-entry and packet read positions.
// - the 8-bit debug index picks packet entries 0-7 and work entries 64-71, reset zero.
// - bit 8 is an active-low enable, reset one, gating the read port onto the debug index.
// - bits 37:9 return the page pointer fifo entry the read port selected.
// - the holding word shows capacity five at 38:36, read position 35:33, entry 32:4.
// - holding bit 3 is an active-low enable reset one, bits 2:0 a debug index reset zero.
// - the port word shows capacity sixteen at 43:37, entry 36:8, enable bit 7, index 6:0.
// - the last fetched packet pointer reads as 29 bits at 28:0.
// - the last fetched work-entry pointer reads as 29 bits, a packet pointer in that mode.
// - eighteen read-only self-test result bits sit at 17:0, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "ipds_regs.vh"
module ipds_bank #(
    parameter PWP_DEPTH  = 128,
    parameter HOLD_DEPTH = 8,
    parameter PORT_DEPTH = 128
) (
    // clock and reset
    input  wire                         i_clk,
    input  wire                         i_rst_n,
    // register port
    input  wire [7:0]                   i_addr,
    input  wire [63:0]                  i_wdata,
    input  wire                         i_wr,
    input  wire                         i_rd,
    output reg  [63:0]                  o_rdata,
    // unit status
    input  wire [`IPDS_POOL_W-1:0]      i_pool0_free_pages,
    input  wire [`IPDS_SELFTEST_W-1:0]  i_selftest_fail,
    input  wire                         i_no_work_entry_pointer_mode,
    // page pointer fifo traffic
    input  wire                         i_pwp_pkt_push,
    input  wire                         i_pwp_we_push,
    input  wire [`IPDS_PTR_W-1:0]       i_pwp_wdata,
    input  wire                         i_pwp_pkt_pop,
    input  wire                         i_pwp_we_pop,
    output wire [`IPDS_PTR_W-1:0]       o_pwp_rd_ptr,
    // holding fifo traffic
    input  wire                         i_hold_push,
    input  wire [`IPDS_PTR_W-1:0]       i_hold_wdata,
    input  wire                         i_hold_pop,
    output wire [`IPDS_PTR_W-1:0]       o_hold_rd_ptr,
    // port fifo traffic
    input  wire                         i_port_push,
    input  wire [`IPDS_PTR_W-1:0]       i_port_wdata,
    input  wire                         i_port_pop,
    output wire [`IPDS_PTR_W-1:0]       o_port_rd_ptr
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // next fifo position, wrapping inside base .. base+cap-1
    function [7:0] next_pos;
        input [7:0] pos;
        input [7:0] base;
        input [7:0] cap;
        begin
            if (pos == base + cap - 8'h01) begin
                next_pos = base;
            end else begin
                next_pos = pos + 8'h01;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // reset
    // ------------------------------------------------------------

    wire rst_n;

    ipds_rst_sync u_rst_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_rst_n (rst_n)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    reg  [`IPDS_POOL_W-1:0]     pool0_free_ff;
    reg  [`IPDS_CYCLE_W-1:0]    cycle_count_ff;
    reg  [`IPDS_SELFTEST_W-1:0] selftest_ff;
    reg  [`IPDS_PTR_W-1:0]      fetch_pkt_ff;
    reg  [`IPDS_PTR_W-1:0]      fetch_we_ff;
    reg                         pwp_en_n_ff;
    reg  [`IPDS_PWP_IDX_W-1:0]  pwp_idx_ff;
    reg                         hold_en_n_ff;
    reg  [`IPDS_HOLD_IDX_W-1:0] hold_idx_ff;
    reg                         port_en_n_ff;
    reg  [`IPDS_PORT_IDX_W-1:0] port_idx_ff;
    reg  [7:0]                  pwp_pkt_wpos_ff;
    reg  [7:0]                  pwp_pkt_rpos_ff;
    reg  [7:0]                  pwp_we_wpos_ff;
    reg  [7:0]                  pwp_we_rpos_ff;
    reg  [7:0]                  hold_wpos_ff;
    reg  [7:0]                  hold_rpos_ff;
    reg  [7:0]                  port_wpos_ff;
    reg  [7:0]                  port_rpos_ff;
    reg                         pkt_pop_d_ff;
    reg                         we_pop_d_ff;
    reg  [63:0]                 nxt_rdata;
    reg  [63:0]                 pwp_word;
    reg  [63:0]                 hold_word;
    reg  [63:0]                 port_word;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------

    wire wr_pwp  = i_wr && (i_addr == `IPDS_OFF_PWP_DEBUG);
    wire wr_hold = i_wr && (i_addr == `IPDS_OFF_HOLD_DEBUG);
    wire wr_port = i_wr && (i_addr == `IPDS_OFF_PORT_DEBUG);

    // only enable and index fields take writes
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwp_en_n_ff  <= `IPDS_EN_N_RST;
            pwp_idx_ff   <= `IPDS_PWP_IDX_RST;
            hold_en_n_ff <= `IPDS_EN_N_RST;
            hold_idx_ff  <= `IPDS_HOLD_IDX_RST;
            port_en_n_ff <= `IPDS_EN_N_RST;
            port_idx_ff  <= `IPDS_PORT_IDX_RST;
        end else begin
            if (wr_pwp) begin
                pwp_en_n_ff <= i_wdata[`IPDS_PWP_EN_BIT];
                pwp_idx_ff  <= i_wdata[`IPDS_PWP_IDX_LSB +: `IPDS_PWP_IDX_W];
            end
            if (wr_hold) begin
                hold_en_n_ff <= i_wdata[`IPDS_HOLD_EN_BIT];
                hold_idx_ff  <= i_wdata[`IPDS_HOLD_IDX_LSB +: `IPDS_HOLD_IDX_W];
            end
            if (wr_port) begin
                port_en_n_ff <= i_wdata[`IPDS_PORT_EN_BIT];
                port_idx_ff  <= i_wdata[`IPDS_PORT_IDX_LSB +: `IPDS_PORT_IDX_W];
            end
        end
    end

    // ------------------------------------------------------------
    // status capture and cycle counter
    // ------------------------------------------------------------

    // pool count and self-test results sampled every cycle
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pool0_free_ff  <= {`IPDS_POOL_W{1'b0}};
            selftest_ff    <= {`IPDS_SELFTEST_W{1'b0}};
            cycle_count_ff <= {`IPDS_CYCLE_W{1'b0}};
        end else begin
            pool0_free_ff  <= i_pool0_free_pages;
            selftest_ff    <= i_selftest_fail;
            cycle_count_ff <= cycle_count_ff + 64'h1;
        end
    end

    // ------------------------------------------------------------
    // page pointer fifo
    // ------------------------------------------------------------

    // work entry pushes are dropped in packet-only mode
    wire pwp_we_push_ok = i_pwp_we_push && !i_no_work_entry_pointer_mode && !i_pwp_pkt_push;
    wire pwp_we_pop_ok  = i_pwp_we_pop && !i_no_work_entry_pointer_mode && !i_pwp_pkt_pop;
    wire pwp_pop_any    = i_pwp_pkt_pop || pwp_we_pop_ok;

    // packet region holds capacity entries from its base, work region likewise
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwp_pkt_wpos_ff <= `IPDS_PWP_PKT_BASE;
            pwp_pkt_rpos_ff <= `IPDS_PWP_PKT_BASE;
            pwp_we_wpos_ff  <= `IPDS_PWP_WE_BASE;
            pwp_we_rpos_ff  <= `IPDS_PWP_WE_BASE;
        end else begin
            if (i_pwp_pkt_push) begin
                pwp_pkt_wpos_ff <= next_pos(pwp_pkt_wpos_ff, `IPDS_PWP_PKT_BASE,
                                            {1'b0, `IPDS_PWP_CAP_VAL});
            end
            if (pwp_we_push_ok) begin
                pwp_we_wpos_ff <= next_pos(pwp_we_wpos_ff, `IPDS_PWP_WE_BASE,
                                           {1'b0, `IPDS_PWP_CAP_VAL});
            end
            if (i_pwp_pkt_pop) begin
                pwp_pkt_rpos_ff <= next_pos(pwp_pkt_rpos_ff, `IPDS_PWP_PKT_BASE,
                                            {1'b0, `IPDS_PWP_CAP_VAL});
            end
            if (pwp_we_pop_ok) begin
                pwp_we_rpos_ff <= next_pos(pwp_we_rpos_ff, `IPDS_PWP_WE_BASE,
                                           {1'b0, `IPDS_PWP_CAP_VAL});
            end
        end
    end

    // read address steered to the debug index while enabled
    wire [6:0] pwp_pop_addr = i_pwp_pkt_pop ? pwp_pkt_rpos_ff[6:0] : pwp_we_rpos_ff[6:0];
    wire [6:0] pwp_debug_read_index    = !pwp_en_n_ff ? pwp_idx_ff[6:0] : pwp_pop_addr;
    wire [6:0] pwp_waddr    = i_pwp_pkt_push ? pwp_pkt_wpos_ff[6:0] : pwp_we_wpos_ff[6:0];

    ipds_ptr_mem #(
        .DEPTH (PWP_DEPTH),
        .AW    (7),
        .DW    (`IPDS_PTR_W)
    ) u_pwp_mem (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_we    (i_pwp_pkt_push || pwp_we_push_ok),
        .i_waddr (pwp_waddr),
        .i_wdata (i_pwp_wdata),
        .i_re_n  (pwp_en_n_ff && !pwp_pop_any),
        .i_debug_read_index (pwp_debug_read_index),
        .o_rdata (o_pwp_rd_ptr)
    );

    // ------------------------------------------------------------
    // fetched pointers
    // ------------------------------------------------------------

    // pops owned by the read port only while debug reading is off
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_pop_d_ff <= 1'b0;
            we_pop_d_ff  <= 1'b0;
            fetch_pkt_ff <= {`IPDS_PTR_W{1'b0}};
            fetch_we_ff  <= {`IPDS_PTR_W{1'b0}};
        end else begin
            pkt_pop_d_ff <= i_pwp_pkt_pop && pwp_en_n_ff;
            we_pop_d_ff  <= pwp_we_pop_ok && pwp_en_n_ff;
            if (pkt_pop_d_ff) begin
                fetch_pkt_ff <= o_pwp_rd_ptr;
            end
            if (we_pop_d_ff || (pkt_pop_d_ff && i_no_work_entry_pointer_mode)) begin
                fetch_we_ff <= o_pwp_rd_ptr;
            end
        end
    end

    // ------------------------------------------------------------
    // holding and port fifos
    // ------------------------------------------------------------

    // positions wrap at the fixed capacity
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_wpos_ff <= 8'h00;
            hold_rpos_ff <= 8'h00;
            port_wpos_ff <= 8'h00;
            port_rpos_ff <= 8'h00;
        end else begin
            if (i_hold_push) begin
                hold_wpos_ff <= next_pos(hold_wpos_ff, 8'h00, {5'h00, `IPDS_HOLD_CAP_VAL});
            end
            if (i_hold_pop) begin
                hold_rpos_ff <= next_pos(hold_rpos_ff, 8'h00,
                                         {5'h00, `IPDS_HOLD_CAP_VAL});
            end
            if (i_port_push) begin
                port_wpos_ff <= next_pos(port_wpos_ff, 8'h00, {1'b0, `IPDS_PORT_CAP_VAL});
            end
            if (i_port_pop) begin
                port_rpos_ff <= next_pos(port_rpos_ff, 8'h00, {1'b0, `IPDS_PORT_CAP_VAL});
            end
        end
    end

    ipds_ptr_mem #(
        .DEPTH (HOLD_DEPTH),
        .AW    (3),
        .DW    (`IPDS_PTR_W)
    ) u_hold_mem (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_we    (i_hold_push),
        .i_waddr (hold_wpos_ff[2:0]),
        .i_wdata (i_hold_wdata),
        .i_re_n  (hold_en_n_ff && !i_hold_pop),
        .i_debug_read_index (!hold_en_n_ff ? hold_idx_ff : hold_rpos_ff[2:0]),
        .o_rdata (o_hold_rd_ptr)
    );

    ipds_ptr_mem #(
        .DEPTH (PORT_DEPTH),
        .AW    (7),
        .DW    (`IPDS_PTR_W)
    ) u_port_mem (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_we    (i_port_push),
        .i_waddr (port_wpos_ff[6:0]),
        .i_wdata (i_port_wdata),
        .i_re_n  (port_en_n_ff && !i_port_pop),
        .i_debug_read_index (!port_en_n_ff ? port_idx_ff : port_rpos_ff[6:0]),
        .o_rdata (o_port_rd_ptr)
    );

    // ------------------------------------------------------------
    // debug word assembly
    // ------------------------------------------------------------

    // reserved positions stay zero
    always @* begin
        pwp_word = 64'h0;
        pwp_word[`IPDS_PWP_CAP_LSB +: `IPDS_PWP_CAP_W]  = `IPDS_PWP_CAP_VAL;
        pwp_word[`IPDS_PWP_EPOS_LSB +: `IPDS_PWP_POS_W] = pwp_we_rpos_ff;
        pwp_word[`IPDS_PWP_PPOS_LSB +: `IPDS_PWP_POS_W] = pwp_pkt_rpos_ff;
        pwp_word[`IPDS_PWP_PTR_LSB +: `IPDS_PTR_W]      = o_pwp_rd_ptr;
        pwp_word[`IPDS_PWP_EN_BIT]                      = pwp_en_n_ff;
        pwp_word[`IPDS_PWP_IDX_LSB +: `IPDS_PWP_IDX_W]  = pwp_idx_ff;
    end

    // holding fifo word
    always @* begin
        hold_word = 64'h0;
        hold_word[`IPDS_HOLD_CAP_LSB +: `IPDS_HOLD_CAP_W] = `IPDS_HOLD_CAP_VAL;
        hold_word[`IPDS_HOLD_POS_LSB +: `IPDS_HOLD_IDX_W] = hold_rpos_ff[2:0];
        hold_word[`IPDS_HOLD_PTR_LSB +: `IPDS_PTR_W]      = o_hold_rd_ptr;
        hold_word[`IPDS_HOLD_EN_BIT]                      = hold_en_n_ff;
        hold_word[`IPDS_HOLD_IDX_LSB +: `IPDS_HOLD_IDX_W] = hold_idx_ff;
    end

    // port fifo word
    always @* begin
        port_word = 64'h0;
        port_word[`IPDS_PORT_CAP_LSB +: `IPDS_PORT_CAP_W] = `IPDS_PORT_CAP_VAL;
        port_word[`IPDS_PORT_PTR_LSB +: `IPDS_PTR_W]      = o_port_rd_ptr;
        port_word[`IPDS_PORT_EN_BIT]                      = port_en_n_ff;
        port_word[`IPDS_PORT_IDX_LSB +: `IPDS_PORT_IDX_W] = port_idx_ff;
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------

    // read mux, unmapped offsets read zero
    always @* begin
        case (i_addr)
            `IPDS_OFF_POOL0_FREE:  nxt_rdata = {32'h0, pool0_free_ff};
            `IPDS_OFF_CYCLE_COUNT: nxt_rdata = cycle_count_ff;
            `IPDS_OFF_PWP_DEBUG:   nxt_rdata = pwp_word;
            `IPDS_OFF_HOLD_DEBUG:  nxt_rdata = hold_word;
            `IPDS_OFF_PORT_DEBUG:  nxt_rdata = port_word;
            `IPDS_OFF_FETCH_PKT:   nxt_rdata = {35'h0, fetch_pkt_ff};
            `IPDS_OFF_FETCH_WE:    nxt_rdata = {35'h0, fetch_we_ff};
            `IPDS_OFF_SELFTEST:    nxt_rdata = {46'h0, selftest_ff};
            default:               nxt_rdata = 64'h0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 64'h0;
        end else if (i_rd) begin
            o_rdata <= nxt_rdata;
        end else begin
            o_rdata <= 64'h0;
        end
    end

endmodule
`default_nettype wire

// >>> design/ipds_regs.vh
// ----------------------------------------------------------------
// register map and field layout of the debug and status bank
// ----------------------------------------------------------------
`ifndef IPDS_REGS_VH
`define IPDS_REGS_VH

// byte offsets, one 64-bit word each
`define IPDS_OFF_POOL0_FREE   8'h00
`define IPDS_OFF_CYCLE_COUNT  8'h08
`define IPDS_OFF_PWP_DEBUG    8'h10
`define IPDS_OFF_HOLD_DEBUG   8'h18
`define IPDS_OFF_PORT_DEBUG   8'h20
`define IPDS_OFF_FETCH_PKT    8'h28
`define IPDS_OFF_FETCH_WE     8'h30
`define IPDS_OFF_SELFTEST     8'h38

// common widths
`define IPDS_PTR_W            29
`define IPDS_POOL_W           32
`define IPDS_CYCLE_W          64
`define IPDS_SELFTEST_W       18

// page pointer fifo debug word
`define IPDS_PWP_CAP_LSB      54
`define IPDS_PWP_CAP_W        7
`define IPDS_PWP_CAP_VAL      7'h08
`define IPDS_PWP_EPOS_LSB     46
`define IPDS_PWP_PPOS_LSB     38
`define IPDS_PWP_POS_W        8
`define IPDS_PWP_PTR_LSB      9
`define IPDS_PWP_EN_BIT       8
`define IPDS_PWP_IDX_LSB      0
`define IPDS_PWP_IDX_W        8
`define IPDS_PWP_PKT_BASE     8'h00
`define IPDS_PWP_WE_BASE      8'h40

// holding fifo debug word
`define IPDS_HOLD_CAP_LSB     36
`define IPDS_HOLD_CAP_W       3
`define IPDS_HOLD_CAP_VAL     3'h5
`define IPDS_HOLD_POS_LSB     33
`define IPDS_HOLD_PTR_LSB     4
`define IPDS_HOLD_EN_BIT      3
`define IPDS_HOLD_IDX_LSB     0
`define IPDS_HOLD_IDX_W       3

// port fifo debug word
`define IPDS_PORT_CAP_LSB     37
`define IPDS_PORT_CAP_W       7
`define IPDS_PORT_CAP_VAL     7'h10
`define IPDS_PORT_PTR_LSB     8
`define IPDS_PORT_EN_BIT      7
`define IPDS_PORT_IDX_LSB     0
`define IPDS_PORT_IDX_W       7

// reset values of writable fields
`define IPDS_EN_N_RST         1'b1
`define IPDS_PWP_IDX_RST      8'h00
`define IPDS_HOLD_IDX_RST     3'h0
`define IPDS_PORT_IDX_RST     7'h00

`endif

// >>> design/ipds_rst_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// reset release synchroniser
// ----------------------------------------------------------------
module ipds_rst_sync (
    // clock and raw reset
    input  wire i_clk,
    input  wire i_rst_n,
    // synchronised reset
    output wire o_rst_n
);
    reg rst_meta_ff;
    reg rst_sync_ff;

    // asserts at once, releases after two edges
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign o_rst_n = rst_sync_ff;
endmodule
`default_nettype wire

// >>> design/ipds_ptr_mem.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// pointer storage, one write port, one registered read port
// ----------------------------------------------------------------
module ipds_ptr_mem #(
    parameter DEPTH = 128,
    parameter AW    = 7,
    parameter DW    = 29
) (
    // clock and reset
    input  wire          i_clk,
    input  wire          i_rst_n,
    // write port
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    // read port
    input  wire          i_re_n,
    input  wire [AW-1:0] i_debug_read_index,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // storage write
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // read register, holds while the read port is disabled
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= {DW{1'b0}};
        end else if (!i_re_n) begin
            o_rdata <= mem[i_debug_read_index];
        end
    end
endmodule
`default_nettype wire

// >>> dv/ipds_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// read answer checks
// ----
module ipds_bank_properties (
    // watched ports
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic        i_rd,
    input wire logic [63:0] o_rdata,
    input wire logic [31:0] i_pool0_free_pages,
    input wire logic [17:0] i_selftest_fail,
    input wire logic        i_pwp_pkt_pop
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // read data against the address read
    chk_pool_value: assert property ($past(i_rd && i_addr == 8'h00) |->
        o_rdata == {32'h0, $past(i_pool0_free_pages, 2)}) else $error("pool read wrong");
    chk_cycle_step: assert property (i_rd && i_addr == 8'h08 ##1 i_rd && i_addr == 8'h08
        |=> o_rdata == $past(o_rdata) + 64'h1) else $error("cycle count step wrong");
    chk_pwp_cap: assert property ($past(i_rd && i_addr == 8'h10) |->
        o_rdata[63:54] == 10'h008) else $error("pwp capacity wrong");
    chk_hold_cap: assert property ($past(i_rd && i_addr == 8'h18) |->
        o_rdata[63:36] == 28'h5) else $error("hold capacity wrong");
    chk_port_cap: assert property ($past(i_rd && i_addr == 8'h20) |->
        o_rdata[63:37] == 27'h10) else $error("port capacity wrong");
    chk_fetch_rsvd: assert property ($past(i_rd && (i_addr[7:3] == 5'h05 || i_addr == 8'h30)) |->
        o_rdata[63:29] == 35'h0) else $error("fetched reserved bits set");
    chk_selftest_map: assert property ($past(i_rd && i_addr == 8'h38) |->
        o_rdata == {46'h0, $past(i_selftest_fail, 2)}) else $error("selftest read wrong");
    chk_unmapped_zero: assert property ($past(i_rd && (i_addr[2:0] != 3'h0 || i_addr >= 8'h40)) |->
        o_rdata == 64'h0) else $error("unmapped read not zero");
    // main scenarios
    cov_pwp_read: cover property (i_rd && i_addr == 8'h10);
    cov_cycle_b2b: cover property (i_rd && i_addr == 8'h08 ##1 i_rd && i_addr == 8'h08);
    cov_pkt_pop: cover property (i_pwp_pkt_pop);
endmodule
`default_nettype wire

// >>> dv/ipds_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ipds_bank_tb;
    logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, mode = 0;
    logic        ppush = 0, wpush = 0, ppop = 0, wpop = 0, hpush = 0, tpush = 0, hpop = 0;
    localparam logic [6:0] PPUSH = 7'h40, WPUSH = 7'h20, PPOP = 7'h10, WPOP = 7'h08;
    localparam logic [6:0] HPUSH = 7'h04, TPUSH = 7'h02, HPOP = 7'h01;
    logic [7:0]  i_addr = 8'h00;
    logic [63:0] i_wdata = 64'h0, o_rdata, d;
    logic [31:0] pool = 32'h1234_5678;
    logic [17:0] sf = 18'h2_0005;
    logic [28:0] pdat = 29'h0, pw_q, ho_q, po_q;
    int          fails = 0, check_count = 0, cyc = 0;
    // design under test
    ipds_bank dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pool0_free_pages(pool),
        .i_selftest_fail(sf), .i_no_work_entry_pointer_mode(mode), .i_pwp_pkt_push(ppush),
        .i_pwp_we_push(wpush), .i_pwp_wdata(pdat), .i_pwp_pkt_pop(ppop), .i_pwp_we_pop(wpop),
        .o_pwp_rd_ptr(pw_q), .i_hold_push(hpush), .i_hold_wdata(pdat), .i_hold_pop(hpop),
        .o_hold_rd_ptr(ho_q), .i_port_push(tpush), .i_port_wdata(pdat), .i_port_pop(1'b0),
        .o_port_rd_ptr(po_q));
    // clock and hang guard
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    // ----
    // shared tasks
    // ----
    task cmp(input string n, input [63:0] e, input [63:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input [7:0] a, input [63:0] w);
        @(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= w; end
        @(posedge i_clk) i_wr <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
        @(posedge i_clk) i_rd <= 0;
        #1 d = o_rdata;
    endtask
    // one-cycle traffic strobes, order ppush wpush ppop wpop hpush tpush hpop
    task pulse(input [6:0] m);
        @(posedge i_clk) {ppush, wpush, ppop, wpop, hpush, tpush, hpop} <= m;
        @(posedge i_clk) {ppush, wpush, ppop, wpop, hpush, tpush, hpop} <= 7'h0;
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task t_reset;
        rd(8'h00); cmp("pool", {32'h0, pool}, d);
        rd(8'h10); cmp("pwp", {10'h008, 8'h40, 8'h00, 29'h0, 1'b1, 8'h00}, d);
        rd(8'h18); cmp("hold", {28'h5, 3'h0, 29'h0, 1'b1, 3'h0}, d);
        rd(8'h20); cmp("port", {27'h10, 29'h0, 1'b1, 7'h0}, d);
        rd(8'h38); cmp("selftest", {46'h0, sf}, d);
        rd(8'h44); cmp("unmapped", 64'h0, d);
        $display("test reset done");
    endtask
    task t_cycle;
        @(posedge i_clk) begin i_rd <= 1; i_addr <= 8'h08; end
        @(posedge i_clk) #1 d = o_rdata;
        @(posedge i_clk) i_rd <= 0;
        #1 cmp("cycle step", d + 64'h1, o_rdata);
        $display("test cycle done");
    endtask
    task t_ro;
        wr(8'h00, '1); wr(8'h38, '1); wr(8'h10, 64'hffff_ffff_ffff_f1c1);
        rd(8'h00); cmp("pool ro", {32'h0, pool}, d);
        rd(8'h38); cmp("selftest ro", {46'h0, sf}, d);
        rd(8'h10); cmp("pwp ro", {10'h008, 8'h40, 8'h00, 29'h0, 9'h1c1}, d);
        wr(8'h10, 64'h100);
        $display("test read-only done");
    endtask
    task t_pwp;
        pdat <= 29'h0abc_def1; pulse(PPUSH); pdat <= 29'h1357_9bdf; pulse(WPUSH);
        wr(8'h10, 64'h0); rd(8'h10); cmp("pkt entry", 29'h0abc_def1, d[37:9]);
        wr(8'h10, 64'h40); rd(8'h10); cmp("we entry", 29'h1357_9bdf, d[37:9]);
        cmp("read port", 29'h1357_9bdf, pw_q);
        wr(8'h10, 64'h100); pulse(PPOP); pulse(WPOP);
        rd(8'h28); cmp("fetched pkt", 29'h0abc_def1, d);
        rd(8'h30); cmp("fetched we", 29'h1357_9bdf, d);
        rd(8'h10); cmp("positions", {8'h41, 8'h01}, d[53:38]);
        pdat <= 29'h0246_8ace; pulse(PPUSH); mode <= 1; pulse(PPOP);
        rd(8'h30); cmp("mode we", 29'h0246_8ace, d);
        rd(8'h10); cmp("mode cap", 7'h08, d[60:54]);
        mode <= 0;
        $display("test page fifo done");
    endtask
    task t_side;
        pdat <= 29'h1ace_0b0e; pulse(HPUSH); pulse(TPUSH);
        wr(8'h18, 64'h0); rd(8'h18); cmp("hold dbg", {28'h5, 3'h0, 29'h1ace_0b0e, 4'h0}, d);
        cmp("hold port", 29'h1ace_0b0e, ho_q);
        wr(8'h18, 64'h8); pulse(HPOP); rd(8'h18);
        cmp("hold pos", {3'h5, 3'h1}, d[38:33]);
        cmp("hold pop", 29'h1ace_0b0e, ho_q);
        wr(8'h20, 64'h0); rd(8'h20);
        cmp("port dbg", {27'h10, 29'h1ace_0b0e, 8'h00}, d);
        cmp("port read", 29'h1ace_0b0e, po_q);
        wr(8'h20, 64'h80);
        $display("test side fifos done");
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1;
        repeat (3) @(posedge i_clk);
        t_reset; t_cycle; t_ro; t_pwp; t_side;
        finish_test;
    end
endmodule
bind ipds_bank ipds_bank_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pool0_free_pages(i_pool0_free_pages),
    .i_selftest_fail(i_selftest_fail), .i_pwp_pkt_pop(i_pwp_pkt_pop));
`default_nettype wire
